//--- src/nfp_top.sv
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "nfp_defines.svh"

module nfp_top
    import nfp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire nfp_acc_req_t acc_req,
    output logic acc_ready,
    output logic acc_done,
    output logic [15:0] acc_rdata,
    output nfp_pins_t flash_pins,
    input wire logic [15:0] flash_dq_i,
    input wire logic flash_ready_busy_n,
    input wire nfp_rs_evt_t rs_evt,
    input wire nfp_rs_rep_t rs_rep,
    output logic ecc_restart,
    output logic rs_select,
    output logic rs_encode,
    output logic nand_irq,
    input wire logic boot_from_nand,
    output logic boot_rom_run
);

    // ==========================================
    // Helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic [15:0] colmask(input int j);
        logic [15:0] m;
        m = 16'h0000;
        for (int b = 0; b < 16; b++) begin
            m[b] = b[j];
        end
        return m;
    endfunction

    // True bit sits above its complement in each pair
    function automatic logic [7:0] pair4(input logic [3:0] t, input logic [3:0] c);
        logic [7:0] p;
        p = 8'h00;
        for (int k = 0; k < 4; k++) begin
            p[2 * k + 1] = t[k];
            p[2 * k] = c[k];
        end
        return p;
    endfunction

    // Report word: reserved gaps read as zero
    function automatic logic [31:0] rep_word(input logic [8:0] pos, input logic [8:0] pat);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`NFP_POS_LSB +: 9] = pos;
        w[`NFP_PAT_LSB +: 9] = pat;
        return w;
    endfunction

    // Codec done enable covers both encode and decode
    function automatic logic [4:0] irq_hits(input logic [4:0] f, input logic [4:0] e);
        logic [4:0] h;
        h[4] = f[`NFP_FLAG_PAD] && e[4];
        h[3] = f[`NFP_FLAG_DEC] && e[3];
        h[2] = (f[`NFP_FLAG_ENC] || f[`NFP_FLAG_DEC]) && e[2];
        h[1] = f[`NFP_FLAG_UNCORRECTABLE_FLAG] && e[1];
        h[0] = f[`NFP_FLAG_ERR] && e[0];
        return h;
    endfunction

    // ==========================================
    // State
    nfp_state_t s;
    nfp_state_t next_s;

    logic wr_csr;
    logic wr_ecc;
    logic wr_flags;
    logic wr_inte;
    logic wr_tim;
    logic ecc_reset;
    logic xfer;
    logic [15:0] word;
    logic [15:0] hw;
    logic rowpar;
    logic [4:0] flag_set;
    logic [4:0] irq_src;
    logic [23:0] parity;
    logic [7:0] par_b2;
    logic seq_idle;

    assign reg_rdata = s.bus_rdata;
    assign acc_done = s.done;
    assign acc_rdata = s.rdata;
    assign flash_pins = s.pin;
    assign nand_irq = s.irq;
    assign boot_rom_run = s.boot;
    assign rs_select = s.rs_sel;
    assign rs_encode = s.enc_sel;
    assign ecc_restart = ecc_reset;

    // Stalls while disabled rather than dropping host traffic
    // Whole one-hot code compared, so a corrupt code never looks idle
    assign seq_idle = s.fsm == NFP_IDLE;
    assign acc_ready = s.en && seq_idle;

    // ==========================================
    // Hamming parity packing
    always_comb begin
        par_b2 = pair4({s.ct[2:0], s.lt[8]}, {s.cc[2:0], s.lc[8]});
        if (s.b256) begin
            par_b2[1:0] = 2'h0;
        end
        // 16-bit parts put all four column pairs in byte 2
        if (s.w16) begin
            par_b2 = pair4(s.ct, s.cc);
        end
        // Byte 0 and 1 follow the word index in both widths
        parity = {par_b2, pair4(s.lt[7:4], s.lc[7:4]), pair4(s.lt[3:0], s.lc[3:0])};
    end

    // ==========================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        wr_csr = reg_wr && hit(reg_addr, `NFP_OFF_CSR);
        wr_ecc = reg_wr && hit(reg_addr, `NFP_OFF_ECC);
        wr_flags = reg_wr && hit(reg_addr, `NFP_OFF_FLAGS);
        wr_inte = reg_wr && hit(reg_addr, `NFP_OFF_INTE);
        wr_tim = reg_wr && hit(reg_addr, `NFP_OFF_TIMING);
        ecc_reset = wr_ecc && reg_wdata[`NFP_ECC_RST];
        xfer = 1'b0;
        word = s.acc_wr ? s.pin.dq_o : flash_dq_i;
        // Upper lane is left out of parity in 8-bit mode
        hw = s.w16 ? word : {8'h00, word[7:0]};
        rowpar = ^hw;

        // ==========================================
        // Control registers
        if (wr_csr) begin
            next_s.en = reg_wdata[`NFP_CSR_EN];
            next_s.hold = reg_wdata[`NFP_CSR_HOLD];
        end
        if (wr_ecc) begin
            next_s.ecc_en = reg_wdata[`NFP_ECC_EN];
            next_s.rs_sel = reg_wdata[`NFP_ECC_RS];
            next_s.enc_sel = reg_wdata[`NFP_ECC_ENC];
            next_s.w16 = reg_wdata[`NFP_ECC_W16];
            next_s.b256 = reg_wdata[`NFP_ECC_B256];
        end
        if (wr_inte) begin
            next_s.inte = reg_wdata[4:0];
        end
        // A count of N gives N+1 cycles in each phase
        if (wr_tim) begin
            next_s.timing = reg_wdata[11:0];
        end

        // Event flags: write 0 clears, a new event wins
        flag_set = {rs_evt.pad, rs_evt.dec, rs_evt.enc, rs_evt.uncorrectable_flag, rs_evt.err};
        if (wr_flags) begin
            next_s.flags = s.flags & reg_wdata[4:0];
        end
        next_s.flags = next_s.flags | flag_set;
        if (ecc_reset) begin
            next_s.error_count_field = 3'h0;
        end
        // A count load beats an ecc reset in the same cycle
        if (rs_evt.cnt_we) begin
            next_s.error_count_field = rs_evt.cnt;
        end

        // ==========================================
        // Error reports
        if (ecc_reset) begin
            next_s.pos = '0;
            next_s.pat = '0;
        end
        // A report write beats an ecc reset in the same cycle
        if (rs_rep.we) begin
            next_s.pos[rs_rep.sel] = rs_rep.pos;
            next_s.pat[rs_rep.sel] = rs_rep.pat;
        end

        // ==========================================
        // Flash cycle sequencer
        case (s.fsm)
            NFP_IDLE: begin
                // Pin controls latch once and stand until hold ends
                if (acc_ready && acc_req.valid) begin
                    next_s.fsm = NFP_SETUP;
                    next_s.cnt = s.timing[`NFP_TIM_SETUP_LSB +: 4];
                    next_s.acc_wr = acc_req.write;
                    next_s.pin.ale = acc_req.space == NFP_SP_ADDR;
                    next_s.pin.cle = acc_req.space == NFP_SP_CMD;
                    next_s.pin.dq_o = acc_req.wdata;
                    next_s.pin.dq_oe = acc_req.write;
                end
            end
            NFP_SETUP: begin
                if (s.cnt == 4'h0) begin
                    next_s.fsm = NFP_STROBE;
                    next_s.cnt = s.timing[`NFP_TIM_STROBE_LSB +: 4];
                    next_s.pin.we_n = ~s.acc_wr;
                    next_s.pin.re_n = s.acc_wr;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            NFP_STROBE: begin
                if (s.cnt == 4'h0) begin
                    next_s.fsm = NFP_HOLD;
                    next_s.cnt = s.timing[`NFP_TIM_HOLD_LSB +: 4];
                    next_s.pin.we_n = 1'b1;
                    next_s.pin.re_n = 1'b1;
                    // Sampled on the last strobe cycle, before the strobe rises
                    if (!s.acc_wr) begin
                        next_s.rdata = flash_dq_i;
                    end
                    // Counted once per word, while read data is still valid
                    xfer = !s.pin.ale && !s.pin.cle;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            NFP_HOLD: begin
                if (s.cnt == 4'h0) begin
                    next_s.fsm = NFP_IDLE;
                    next_s.pin.ale = 1'b0;
                    next_s.pin.cle = 1'b0;
                    next_s.pin.dq_oe = 1'b0;
                    // Done pulses one cycle as the sequencer returns to idle
                    next_s.done = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                // A corrupt state code recovers to idle
                next_s.fsm = NFP_IDLE;
            end
        endcase

        // ==========================================
        // Hamming accumulator
        if (ecc_reset) begin
            next_s.lt = 9'h000;
            next_s.lc = 9'h000;
            next_s.ct = 4'h0;
            next_s.cc = 4'h0;
            next_s.idx = 9'h000;
        end else if (xfer && s.ecc_en && !s.rs_sel) begin
            for (int i = 0; i < 9; i++) begin
                if (s.idx[i]) begin
                    next_s.lt[i] = s.lt[i] ^ rowpar;
                end else begin
                    next_s.lc[i] = s.lc[i] ^ rowpar;
                end
            end
            for (int j = 0; j < 4; j++) begin
                next_s.ct[j] = s.ct[j] ^ (^(hw & colmask(j)));
                next_s.cc[j] = s.cc[j] ^ (^(hw & ~colmask(j)));
            end
            next_s.idx = s.idx + 9'h001;
        end

        // Chip select from hold bit while enabled, or an access in flight
        next_s.pin.cs_n = ~((next_s.en && next_s.hold) || (next_s.fsm != NFP_IDLE));

        // Request follows the enabled flags of the next cycle
        irq_src = irq_hits(next_s.flags, next_s.inte);
        next_s.irq = |irq_src;

        // ==========================================
        // Register read port
        next_s.bus_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                // Ready comes live from the pin, not from a register
                `NFP_OFF_CSR: begin
                    next_s.bus_rdata = {29'h0, flash_ready_busy_n, s.hold, s.en};
                end
                // Reset bit is a pulse and always reads back zero
                `NFP_OFF_ECC: begin
                    next_s.bus_rdata = {26'h0, s.b256, s.w16, s.enc_sel, s.rs_sel, 1'b0, s.ecc_en};
                end
                `NFP_OFF_PAR: begin
                    next_s.bus_rdata = {8'h00, parity};
                end
                `NFP_OFF_FLAGS: begin
                    next_s.bus_rdata = {s.error_count_field, 24'h0, s.flags};
                end
                `NFP_OFF_INTE: begin
                    next_s.bus_rdata = {27'h0, s.inte};
                end
                `NFP_OFF_REP0: begin
                    next_s.bus_rdata = rep_word(s.pos[0], s.pat[0]);
                end
                `NFP_OFF_REP1: begin
                    next_s.bus_rdata = rep_word(s.pos[1], s.pat[1]);
                end
                `NFP_OFF_REP2: begin
                    next_s.bus_rdata = rep_word(s.pos[2], s.pat[2]);
                end
                `NFP_OFF_REP3: begin
                    next_s.bus_rdata = rep_word(s.pos[3], s.pat[3]);
                end
                `NFP_OFF_TIMING: begin
                    next_s.bus_rdata = {20'h0, s.timing};
                end
                default: begin
                    next_s.bus_rdata = 32'h0000_0000;
                end
            endcase
        end

        // Strap is sampled once, on the first edge after release
        next_s.strap_done = 1'b1;
        if (!s.strap_done) begin
            next_s.boot = boot_from_nand;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            // Strobes and select rest high while in reset
            s.fsm <= NFP_IDLE;
            s.pin.cs_n <= 1'b1;
            s.pin.re_n <= 1'b1;
            s.pin.we_n <= 1'b1;
            s.timing <= `NFP_TIMING_RST;
            s.inte <= `NFP_INTE_RST;
        end else begin
            s <= next_s;
        end
    end

endmodule
`default_nettype wire

//--- src/nfp_defines.svh
`ifndef NFP_DEFINES_SVH
`define NFP_DEFINES_SVH

// ==========================================
// Register offsets (byte addresses)
`define NFP_OFF_CSR 8'h00
`define NFP_OFF_ECC 8'h04
`define NFP_OFF_PAR 8'h08
`define NFP_OFF_FLAGS 8'h0C
`define NFP_OFF_INTE 8'h10
`define NFP_OFF_REP0 8'h14
`define NFP_OFF_REP1 8'h18
`define NFP_OFF_REP2 8'h1C
`define NFP_OFF_REP3 8'h20
`define NFP_OFF_TIMING 8'h24

// ==========================================
// Field positions
`define NFP_CSR_EN 0
`define NFP_CSR_HOLD 1
`define NFP_CSR_READY 2
`define NFP_ECC_EN 0
`define NFP_ECC_RST 1
`define NFP_ECC_RS 2
`define NFP_ECC_ENC 3
`define NFP_ECC_W16 4
`define NFP_ECC_B256 5
`define NFP_FLAG_PAD 4
`define NFP_FLAG_DEC 3
`define NFP_FLAG_ENC 2
`define NFP_FLAG_UNCORRECTABLE_FLAG 1
`define NFP_FLAG_ERR 0
`define NFP_ERROR_COUNT_FIELD_LSB 29
`define NFP_POS_LSB 16
`define NFP_PAT_LSB 0
`define NFP_TIM_SETUP_LSB 0
`define NFP_TIM_STROBE_LSB 4
`define NFP_TIM_HOLD_LSB 8

// ==========================================
// Reset values
`define NFP_TIMING_RST 12'hFFF
`define NFP_INTE_RST 5'h00

`endif

//--- src/nfp_pkg.sv
package nfp_pkg;

    // ==========================================
    // Enumerations
    typedef enum logic [3:0] {
        NFP_IDLE = 4'h1,
        NFP_SETUP = 4'h2,
        NFP_STROBE = 4'h4,
        NFP_HOLD = 4'h8
    } nfp_fsm_t;

    typedef enum logic [1:0] {
        NFP_SP_DATA = 2'h0,
        NFP_SP_CMD = 2'h1,
        NFP_SP_ADDR = 2'h2
    } nfp_space_t;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic write;
        nfp_space_t space;
        logic [15:0] wdata;
    } nfp_acc_req_t;

    typedef struct packed {
        logic cs_n;
        logic re_n;
        logic we_n;
        logic ale;
        logic cle;
        logic [15:0] dq_o;
        logic dq_oe;
    } nfp_pins_t;

    typedef struct packed {
        logic pad;
        logic dec;
        logic enc;
        logic uncorrectable_flag;
        logic err;
        logic cnt_we;
        logic [2:0] cnt;
    } nfp_rs_evt_t;

    typedef struct packed {
        logic we;
        logic [1:0] sel;
        logic [8:0] pos;
        logic [8:0] pat;
    } nfp_rs_rep_t;

    typedef struct packed {
        nfp_fsm_t fsm;
        logic [3:0] cnt;
        logic acc_wr;
        nfp_pins_t pin;
        logic [15:0] rdata;
        logic done;
        logic en;
        logic hold;
        logic ecc_en;
        logic rs_sel;
        logic enc_sel;
        logic w16;
        logic b256;
        logic [11:0] timing;
        logic [4:0] flags;
        logic [2:0] error_count_field;
        logic [4:0] inte;
        logic [3:0][8:0] pos;
        logic [3:0][8:0] pat;
        logic [8:0] lt;
        logic [8:0] lc;
        logic [3:0] ct;
        logic [3:0] cc;
        logic [8:0] idx;
        logic [31:0] bus_rdata;
        logic irq;
        logic strap_done;
        logic boot;
    } nfp_state_t;

endpackage

//--- verification/nfp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module nfp_flash_model
    import nfp_pkg::*;
#(
    parameter logic [15:0] RD_WORD = 16'hA5C3,
    parameter int BUSY_CYC = 20
)(
    input wire logic mclk,
    input wire nfp_pins_t pins,
    output logic [15:0] dq_i,
    output logic rb_n,
    output logic [1:0] last_kind,
    output logic [15:0] last_word
);
    // ==========================================
    // Flash device
    logic prev_we = 1'h1;
    logic [15:0] junk = 16'h0F0F;
    int busy = 0;
    always @(posedge mclk) begin
        prev_we <= pins.we_n;
        junk <= ~junk;
        if (busy > 0) begin
            busy <= busy - 1;
        end
        // Latch when the write strobe returns high
        if (pins.we_n && !prev_we && !pins.cs_n) begin
            last_kind <= {pins.cle, pins.ale};
            last_word <= pins.dq_o;
            if (pins.cle) begin
                busy <= BUSY_CYC;
            end
        end
    end
    // Released bus never holds a stale value
    assign dq_i = (!pins.re_n && !pins.cs_n) ? RD_WORD : junk;
    assign rb_n = (busy == 0);
endmodule
`default_nettype wire

//--- verification/nfp_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nfp_top_chk
    import nfp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire nfp_acc_req_t acc_req,
    input wire logic acc_ready,
    input wire logic acc_done,
    input wire nfp_pins_t flash_pins,
    input wire logic ecc_restart,
    input wire logic boot_from_nand,
    input wire logic boot_rom_run
);
    // ==========================================
    // Port rules
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    wire logic take = acc_req.valid && acc_ready;
    inte_rsvd_a: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata[31:5] == 27'h0)
        else $error("enable reserved bits not zero");
    report_rsvd_a: assert property (
        $past(reg_rd) && $past(reg_addr) inside {8'h14, 8'h18, 8'h1C, 8'h20}
        |-> reg_rdata[31:25] == 7'h0 && reg_rdata[15:9] == 7'h0)
        else $error("report reserved bits not zero");
    addr_cycle_a: assert property (
        take && acc_req.write && acc_req.space == NFP_SP_ADDR
        |=> flash_pins.ale && !flash_pins.cle && flash_pins.dq_oe)
        else $error("no address cycle");
    cmd_cycle_a: assert property (
        take && acc_req.write && acc_req.space == NFP_SP_CMD
        |=> flash_pins.cle && !flash_pins.ale && flash_pins.dq_oe)
        else $error("no command cycle");
    data_read_a: assert property (
        take && !acc_req.write && acc_req.space == NFP_SP_DATA
        |=> !flash_pins.dq_oe && !flash_pins.ale && !flash_pins.cle ##[1:16] !flash_pins.re_n)
        else $error("no data read cycle");
    access_time_a: assert property (
        take |-> ##[4:49] acc_done)
        else $error("access did not complete");
    strobe_cs_a: assert property (
        !flash_pins.we_n || !flash_pins.re_n |-> !flash_pins.cs_n)
        else $error("strobe without chip select");
    disable_a: assert property (
        reg_wr && reg_addr == 8'h00 && !reg_wdata[0] |=> (!acc_ready) [*2])
        else $error("access taken while disabled");
    restart_a: assert property (
        reg_wr && reg_addr == 8'h04 && reg_wdata[1] |-> ecc_restart)
        else $error("ecc restart missing");
    boot_a: assert property (
        $rose(nrst) |=> boot_rom_run == $past(boot_from_nand))
        else $error("boot strap not captured");
endmodule
bind nfp_top nfp_top_chk chk (.*);
`default_nettype wire

//--- verification/nfp_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nfp_top_tb_top
    import nfp_pkg::*;
;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic [31:0] reg_rdata;
    nfp_acc_req_t acc_req = '0;
    nfp_rs_evt_t rs_evt = '0;
    nfp_rs_rep_t rs_rep = '0;
    nfp_pins_t pins;
    logic acc_ready, acc_done, nand_irq, rb_n;
    logic [15:0] acc_rdata, dq_i, last_word;
    logic [1:0] last_kind;
    logic boot_strap = 1'h1;
    logic boot_run, rs_sel, rs_enc;
    int mismatches = 0;
    int compares = 0;
    int n;
    always #5 mclk = ~mclk;
    nfp_top uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_ready(acc_ready), .acc_done(acc_done),
        .acc_rdata(acc_rdata), .flash_pins(pins), .flash_dq_i(dq_i), .flash_ready_busy_n(rb_n), .rs_evt(rs_evt),
        .rs_rep(rs_rep), .ecc_restart(), .rs_select(rs_sel), .rs_encode(rs_enc), .nand_irq(nand_irq),
        .boot_from_nand(boot_strap), .boot_rom_run(boot_run));
    nfp_flash_model flash (.mclk(mclk), .pins(pins), .dq_i(dq_i), .rb_n(rb_n), .last_kind(last_kind),
        .last_word(last_word));
    // ==========================================
    // Access tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string nm);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        chk(nm, e, reg_rdata & m);
    endtask
    // Holds the request until ready, drops valid once taken, then counts negedges up to done
    task automatic acc(input nfp_space_t sp, input logic w, input logic [15:0] d, output int cyc);
        @(posedge mclk);
        acc_req <= {1'h1, w, sp, d};
        cyc = 0;
        do @(negedge mclk); while (acc_ready !== 1'h1 && ++cyc < 50);
        @(posedge mclk);
        acc_req.valid <= 1'h0;
        cyc = 0;
        do @(negedge mclk); while (acc_done !== 1'h1 && ++cyc < 60);
    endtask
    task automatic evt(input int i);
        @(posedge mclk);
        rs_evt <= 9'(1 << (i + 4));
        @(posedge mclk);
        rs_evt <= '0;
    endtask
    task automatic irq_on(input int e, input int i);
        wr(8'h10, 32'(1 << e));
        evt(i);
        repeat (2) @(negedge mclk);
        chk("irq", 32'h1, {31'h0, nand_irq});
        wr(8'h0C, 32'h0);
        repeat (2) @(negedge mclk);
        chk("irq clear", 32'h0, {31'h0, nand_irq});
    endtask
    task automatic hm(input logic [31:0] c, input logic [15:0] d, input logic [31:0] e, m);
        wr(8'h04, c);
        acc(NFP_SP_DATA, 1'h1, 16'h0000, n);
        acc(NFP_SP_DATA, 1'h1, d, n);
        wr(8'h04, c & 32'h30);
        acc(NFP_SP_DATA, 1'h1, 16'hFFFF, n);
        rd(8'h08, m, e, "parity");
    endtask
    task automatic results;
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #300000;
        mismatches++;
        results();
    end
    // ==========================================
    // Tests
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'h1;
        rd(8'h10, '1, 32'h0, "enable reset");
        chk("boot", 32'h1, {31'h0, boot_run});
        rd(8'h40, '1, 32'h0, "unmapped");
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, '1, 32'h1F, "enable bits");
        for (int i = 0; i < 5; i++) begin
            wr(8'h10, 32'h0);
            evt(i);
            rd(8'h0C, 32'h1F, 32'(1 << i), "flags");
            chk("irq masked", 32'h0, {31'h0, nand_irq});
            irq_on(i, i);
        end
        irq_on(2, 3);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            rs_rep <= {1'h1, 2'(i), 9'h1FF - 9'(i), 9'(9'h0AB << i)};
            @(posedge mclk);
            rs_rep <= '0;
            wr(8'(8'h14 + 4 * i), 32'hFFFFFFFF);
            rd(8'(8'h14 + 4 * i), '1, {7'h0, 9'h1FF - 9'(i), 7'h0, 9'(9'h0AB << i)}, "report");
        end
        @(posedge mclk);
        rs_evt <= 9'h00B;
        @(posedge mclk);
        rs_evt <= '0;
        rd(8'h0C, 32'hE0000000, 32'h60000000, "error count");
        wr(8'h04, 32'h2);
        rd(8'h0C, 32'hE0000000, 32'h0, "error count clear");
        for (int i = 0; i < 4; i++) begin
            rd(8'(8'h14 + 4 * i), '1, 32'h0, "report clear");
        end
        wr(8'h24, 32'h0);
        @(posedge mclk);
        acc_req <= {1'h1, 1'h1, NFP_SP_CMD, 16'h00FF};
        repeat (3) @(negedge mclk);
        chk("ready disabled", 32'h0, {31'h0, acc_ready});
        chk("cs disabled", 32'h1, {31'h0, pins.cs_n});
        @(posedge mclk);
        acc_req <= '0;
        wr(8'h00, 32'h1);
        acc(NFP_SP_CMD, 1'h1, 16'h0080, n);
        chk("cmd", 32'h20080, {last_kind, 8'h0, last_word[7:0]});
        chk("cycles", 32'd3, n);
        chk("cs idle", 32'h1, {31'h0, pins.cs_n});
        acc(NFP_SP_ADDR, 1'h1, 16'h0012, n);
        chk("addr", 32'h10012, {last_kind, 8'h0, last_word[7:0]});
        wr(8'h24, 32'h123);
        acc(NFP_SP_DATA, 1'h1, 16'h005A, n);
        chk("data", 32'h5A, {last_kind, 8'h0, last_word[7:0]});
        chk("slow cycles", 32'd9, n);
        acc(NFP_SP_DATA, 1'h0, 16'h0000, n);
        chk("read", 32'hC3, {24'h0, acc_rdata[7:0]});
        wr(8'h24, 32'h0);
        acc(NFP_SP_CMD, 1'h1, 16'h0010, n);
        rd(8'h00, 32'h4, 32'h0, "busy");
        repeat (30) @(posedge mclk);
        rd(8'h00, 32'h4, 32'h4, "ready");
        wr(8'h00, 32'h3);
        repeat (2) @(negedge mclk);
        chk("cs hold", 32'h0, {31'h0, pins.cs_n});
        hm(32'h03, 16'h0080, 32'hA95556, 32'hFFFFFF);
        hm(32'h23, 16'h0080, 32'hA85556, 32'hFCFFFF);
        hm(32'h13, 16'h8000, 32'hAA5556, 32'hFFFFFF);
        wr(8'h04, 32'h0C);
        repeat (2) @(negedge mclk);
        chk("rs select", 32'h3, {30'h0, rs_sel, rs_enc});
        wr(8'h00, 32'h0);
        repeat (2) @(negedge mclk);
        chk("ready off", 32'h0, {31'h0, acc_ready});
        chk("cs released", 32'h1, {31'h0, pins.cs_n});
        results();
    end
endmodule
`default_nettype wire
